//--- core/msu_fifo.v
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module msu_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire rst,
    input wire clr,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (rst || clr) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // msu_fifo

//--- core/msu_regs.vh
// Constants for the serial port: register select, field positions, reset values and bit timing.
`ifndef MSU_REGS_VH
`define MSU_REGS_VH
// --------------------------------------------------------------------------
// Register select (address bit zero)
// --------------------------------------------------------------------------
`define MSU_SEL_CMD_STATUS 1'h0
`define MSU_SEL_DATA 1'h1
// --------------------------------------------------------------------------
// Command fields
// --------------------------------------------------------------------------
`define MSU_CMD_RATE_LO 0
`define MSU_CMD_RATE_HI 1
`define MSU_CMD_TXC_LO 5
`define MSU_CMD_TXC_HI 6
`define MSU_CMD_RX_IRQ_EN 7
`define MSU_CMD_RESET_VAL 8'h03
`define MSU_RATE_9K6 2'h0
`define MSU_RATE_31K25 2'h1
`define MSU_RATE_38K4 2'h2
`define MSU_RATE_OFF 2'h3
`define MSU_TXC_NOIRQ_RTS_LO 2'h0
`define MSU_TXC_IRQ 2'h1
`define MSU_TXC_NOIRQ_RTS_HI 2'h2
`define MSU_TXC_BREAK 2'h3
// --------------------------------------------------------------------------
// Status fields
// --------------------------------------------------------------------------
`define MSU_ST_RX_FULL 0
`define MSU_ST_TX_EMPTY 1
`define MSU_ST_CTS 3
`define MSU_ST_FRAMING 4
`define MSU_ST_OVERRUN 5
`define MSU_ST_IRQ 7
// --------------------------------------------------------------------------
// Bit timing at 20 MHz: rate in Hz, cycles per bit rounded down
// --------------------------------------------------------------------------
`define MSU_CLK_HZ 20000000
`define MSU_BAUD_9K6_HZ 9600
`define MSU_BAUD_31K25_HZ 31250
`define MSU_BAUD_38K4_HZ 38400
`define MSU_BIT_CYC_9K6 (`MSU_CLK_HZ / `MSU_BAUD_9K6_HZ)
`define MSU_BIT_CYC_31K25 (`MSU_CLK_HZ / `MSU_BAUD_31K25_HZ)
`define MSU_BIT_CYC_38K4 (`MSU_CLK_HZ / `MSU_BAUD_38K4_HZ)
`define MSU_FIFO_WIDTH 8
`define MSU_FIFO_DEPTH 16
`endif

//--- core/msu_uart.v
// Host-facing serial port with command/status and data registers.
//
// Summary of operation
// - Select low; address bit zero picks command/status (0) or data (1).
// - After reset rate is 11; port idle, apart from break driving the line low, until a valid rate is written.
// - Writing rate code 11 resets transmit and receive state.
// - Rate codes 00, 01, 10 give 9.6, 31.25, 38.4 kHz.
// - Command bits 6:5 set transmit interrupt, request-to-send and break.
// - Command bit 7 enables interrupt on receive full or overrun.
// - Status bit 0 sets on received byte, clears on data read.
// - Status bit 1 clears on data write, sets when the last buffered byte enters shifter.
// - Status bit 3 shows the active-low clear-to-send pin.
// - Clear-to-send inactive forces the transmit-empty bit to zero.
// - Status bit 4 flags missing stop bit for the held character.
// - Status bit 5 sets when unread received byte is overwritten.
// - Overrun bit clears when the host reads the data register.
// - Status bit 7 reads one exactly while interrupt is pending.
// - Data address writes transmit buffer and reads receive buffer.
`timescale 1ns/100ps
`include "msu_regs.vh"
module msu_uart (
    input wire clk_sys,
    input wire rst,
    input wire serial_port_select_n,
    input wire [1:0] addr,
    input wire rd_stb,
    input wire wr_stb,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    input wire rx_line,
    input wire cts_n,
    output wire tx_line,
    output wire rts_n,
    output wire irq
);
    // ----------------------------------------------------------------------
    // Host access
    // ----------------------------------------------------------------------
    // Decodes one host strobe against the select and address bit zero.
    function reg_hit;
        input sel_n;
        input stb;
        input a0;
        input want;
        begin
            reg_hit = !sel_n && stb && (a0 == want);
        end
    endfunction

    wire cmd_wr = reg_hit(serial_port_select_n, wr_stb, addr[0], `MSU_SEL_CMD_STATUS);
    wire data_wr = reg_hit(serial_port_select_n, wr_stb, addr[0], `MSU_SEL_DATA);
    wire data_rd = reg_hit(serial_port_select_n, rd_stb, addr[0], `MSU_SEL_DATA);
    wire st_rd = reg_hit(serial_port_select_n, rd_stb, addr[0], `MSU_SEL_CMD_STATUS);

    // ----------------------------------------------------------------------
    // Command register
    // ----------------------------------------------------------------------
    reg [7:0] cmd_q;
    wire [1:0] rate = cmd_q[`MSU_CMD_RATE_HI:`MSU_CMD_RATE_LO];
    wire [1:0] txc = cmd_q[`MSU_CMD_TXC_HI:`MSU_CMD_TXC_LO];
    wire active = (rate != `MSU_RATE_OFF);
    wire rate_off_wr = cmd_wr && (wr_data[`MSU_CMD_RATE_HI:`MSU_CMD_RATE_LO] == `MSU_RATE_OFF);
    wire soft_rst = rst || rate_off_wr || !active;

    always @(posedge clk_sys) begin
        if (rst) begin
            cmd_q <= `MSU_CMD_RESET_VAL;
        end else if (cmd_wr) begin
            cmd_q <= wr_data;
        end
    end

    // ----------------------------------------------------------------------
    // Bit timing
    // ----------------------------------------------------------------------
    function [15:0] bit_cycles;
        input [1:0] code;
        reg [31:0] cyc;
        begin
            case (code)
                `MSU_RATE_9K6: cyc = `MSU_BIT_CYC_9K6;
                `MSU_RATE_31K25: cyc = `MSU_BIT_CYC_31K25;
                default: cyc = `MSU_BIT_CYC_38K4;
            endcase
            bit_cycles = cyc[15:0];
        end
    endfunction

    // A count at or past the last cycle ends the bit, so a rate change mid-bit cannot wrap the counter.
    function bit_done;
        input [15:0] cnt;
        input [15:0] len;
        begin
            bit_done = (cnt >= len - 16'h0001);
        end
    endfunction
    wire [15:0] bit_len = bit_cycles(rate);

    // ----------------------------------------------------------------------
    // Transmit buffer path
    // ----------------------------------------------------------------------
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [7:0] fifo_out_data;
    msu_fifo #(
        .WIDTH(`MSU_FIFO_WIDTH),
        .DEPTH(`MSU_FIFO_DEPTH),
        .AW(4)
    ) u_txbuf (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(soft_rst),
        .in_valid(data_wr),
        .in_ready(fifo_in_ready),
        .in_data(wr_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ----------------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------------
    localparam TX_IDLE = 1'b0;
    localparam TX_SHIFT = 1'b1;
    reg tx_st_q;
    reg [15:0] tx_cnt_q;
    reg [3:0] tx_bit_q;
    reg [9:0] tx_sh_q;
    wire tx_break = (txc == `MSU_TXC_BREAK);
    assign fifo_out_ready = active && (tx_st_q == TX_IDLE) && !cts_n && !tx_break;

    always @(posedge clk_sys) begin
        if (soft_rst) begin
            tx_st_q <= TX_IDLE;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 10'h3FF;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    if (fifo_out_valid && fifo_out_ready) begin
                        tx_sh_q <= {1'b1, fifo_out_data, 1'b0};
                        tx_cnt_q <= 16'h0000;
                        tx_bit_q <= 4'h0;
                        tx_st_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (bit_done(tx_cnt_q, bit_len)) begin
                        tx_cnt_q <= 16'h0000;
                        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                        if (tx_bit_q == 4'h9) begin
                            tx_st_q <= TX_IDLE;
                        end else begin
                            tx_bit_q <= tx_bit_q + 4'h1;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 16'h0001;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end
    assign tx_line = tx_break ? 1'b0 : tx_sh_q[0];
    assign rts_n = (txc == `MSU_TXC_NOIRQ_RTS_HI);

    wire tx_empty = !fifo_out_valid && !cts_n;

    // ----------------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------------
    localparam RX_IDLE = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA = 2'h2;
    localparam RX_STOP = 2'h3;
    reg [1:0] rx_st_q;
    reg rx_s1_q;
    reg rx_s2_q;
    reg [15:0] rx_cnt_q;
    reg [2:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg [7:0] rx_buf_q;
    reg rx_full_flag_q;
    reg framing_error_flag_q;
    reg overrun_flag_q;
    reg rx_done;
    reg rx_done_fe;

    // ----------------------------------------------------------------------
    // Receive synchroniser
    // ----------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= rx_line;
            rx_s2_q <= rx_s1_q;
        end
    end

    always @(posedge clk_sys) begin
        rx_done <= 1'b0;
        rx_done_fe <= 1'b0;
        if (soft_rst) begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
        end else begin
            case (rx_st_q)
                RX_IDLE: begin
                    rx_cnt_q <= 16'h0000;
                    if (!rx_s2_q) begin
                        rx_st_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_q >= {1'b0, bit_len[15:1]}) begin
                        rx_cnt_q <= 16'h0000;
                        rx_bit_q <= 3'h0;
                        rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                    end
                end
                RX_DATA: begin
                    if (bit_done(rx_cnt_q, bit_len)) begin
                        rx_cnt_q <= 16'h0000;
                        rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7) begin
                            rx_st_q <= RX_STOP;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                    end
                end
                RX_STOP: begin
                    if (bit_done(rx_cnt_q, bit_len)) begin
                        rx_done <= 1'b1;
                        rx_done_fe <= !rx_s2_q;
                        rx_st_q <= RX_IDLE;
                    end else begin
                        rx_cnt_q <= rx_cnt_q + 16'h0001;
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Receive buffer and flags
    // ----------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (soft_rst) begin
            rx_buf_q <= 8'h00;
        end else if (rx_done) begin
            rx_buf_q <= rx_sh_q;
        end
    end

    // A new byte arriving with a host read wins over the clear.
    always @(posedge clk_sys) begin
        if (soft_rst) begin
            rx_full_flag_q <= 1'b0;
        end else if (rx_done) begin
            rx_full_flag_q <= 1'b1;
        end else if (data_rd) begin
            rx_full_flag_q <= 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (soft_rst) begin
            framing_error_flag_q <= 1'b0;
        end else if (rx_done) begin
            framing_error_flag_q <= rx_done_fe;
        end
    end

    always @(posedge clk_sys) begin
        if (soft_rst) begin
            overrun_flag_q <= 1'b0;
        end else if (rx_done && rx_full_flag_q && !data_rd) begin
            overrun_flag_q <= 1'b1;
        end else if (data_rd) begin
            overrun_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // Interrupt and status
    // ----------------------------------------------------------------------
    wire irq_rx = cmd_q[`MSU_CMD_RX_IRQ_EN] && (rx_full_flag_q || overrun_flag_q);
    wire irq_tx = (txc == `MSU_TXC_IRQ) && tx_empty;
    assign irq = active && (irq_rx || irq_tx);

    wire [7:0] status;
    assign status[`MSU_ST_RX_FULL] = rx_full_flag_q;
    assign status[`MSU_ST_TX_EMPTY] = tx_empty;
    assign status[2] = 1'b0;
    assign status[`MSU_ST_CTS] = cts_n;
    assign status[`MSU_ST_FRAMING] = framing_error_flag_q;
    assign status[`MSU_ST_OVERRUN] = overrun_flag_q;
    assign status[6] = 1'b0;
    assign status[`MSU_ST_IRQ] = irq;

    // ----------------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (data_rd) begin
            rd_data <= rx_buf_q;
        end else if (st_rd) begin
            rd_data <= status;
        end
    end
endmodule // msu_uart

//--- dv/msu_peer.sv
// Serial line partner that receives and sends frames.
`timescale 1ns/100ps
module msu_peer (
    input wire clk_sys,
    input wire tx_line,
    output logic rx_line
);
    int bit_cyc = 640;
    logic [7:0] got[$];
    logic [7:0] sh;
    initial rx_line = 1'b1;
    always begin
        @(negedge tx_line);
        repeat (bit_cyc / 2) @(posedge clk_sys);
        if (!tx_line) begin
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge clk_sys);
                sh[i] = tx_line;
            end
            repeat (bit_cyc) @(posedge clk_sys);
            if (tx_line) got.push_back(sh);
        end
    end
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        @(posedge clk_sys);
        #1;
        for (int i = 0; i < 10; i++) begin
            rx_line = f[i];
            repeat (bit_cyc) @(posedge clk_sys);
            #1;
        end
        rx_line = 1'b1;
    endtask
endmodule // msu_peer

//--- dv/msu_uart_checker.sv
// Concurrent checks on the serial port pins.
`timescale 1ns/100ps
module msu_uart_checker (
    input wire clk_sys,
    input wire rst,
    input wire serial_port_select_n,
    input wire [1:0] addr,
    input wire rd_stb,
    input wire wr_stb,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data,
    input wire rx_line,
    input wire cts_n,
    input wire tx_line,
    input wire rts_n,
    input wire irq
);
    reg [7:0] cmd_q;
    wire act = cmd_q[1:0] != 2'h3;
    always @(posedge clk_sys) begin
        if (rst) cmd_q <= 8'h03;
        else if (wr_stb && !serial_port_select_n && !addr[0]) cmd_q <= wr_data;
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_st_rd;
        rd_stb && !serial_port_select_n && !addr[0];
    endsequence
    sequence s_dat_rd;
        rd_stb && !serial_port_select_n && addr[0];
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) rst |=> tx_line && !irq && rd_data == 8'h00)
        else $error("reset state wrong");
    a_idle_line: assert property (!act && $past(cmd_q[1:0]) == 2'h3 && cmd_q[6:5] != 2'h3 |-> tx_line && !irq)
        else $error("inactive port not idle");
    a_break_low: assert property (act && cmd_q[6:5] == 2'h3 |-> !tx_line)
        else $error("break not sent");
    a_rts_level: assert property (rts_n == (cmd_q[6:5] == 2'h2))
        else $error("rts level wrong");
    a_irq_source: assert property (!cmd_q[7] && cmd_q[6:5] != 2'h1 |-> !irq)
        else $error("irq without enable");
    a_status_irq: assert property (s_st_rd |=> rd_data[7] == $past(irq))
        else $error("irq status differs from pin");
    a_cts_mirror: assert property (cts_n [*3] ##0 s_st_rd |=> rd_data[3] && !rd_data[1])
        else $error("cts status wrong");
    a_start_bit: assert property (act && cmd_q[6:5] != 2'h3 && $fell(tx_line) |-> !tx_line [*8])
        else $error("start bit too short");
    a_read_clears: assert property (s_dat_rd ##2 s_st_rd |=> !rd_data[0] && !rd_data[5])
        else $error("flags not cleared by read");
endmodule // msu_uart_checker

//--- dv/tb_msu_uart.sv
// Self-checking bench for the serial port.
`timescale 1ns/100ps
module tb_msu_uart;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sel_n = 1'b1;
    logic [1:0] addr = 2'h0;
    logic rd_stb = 1'b0;
    logic wr_stb = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic cts_n = 1'b0;
    wire [7:0] rd_data;
    wire rx_line, tx_line, rts_n, irq;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] lfsr_q = 32'h00012BBD;
    logic [7:0] exp_q[$];
    always #25 clk_sys = ~clk_sys;
    msu_uart u_dut (.clk_sys(clk_sys), .rst(rst), .serial_port_select_n(sel_n), .addr(addr), .rd_stb(rd_stb),
        .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .rx_line(rx_line), .cts_n(cts_n),
        .tx_line(tx_line), .rts_n(rts_n), .irq(irq));
    msu_peer u_peer (.clk_sys(clk_sys), .tx_line(tx_line), .rx_line(rx_line));
    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[7:0];
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic a, input logic [7:0] di, output logic [7:0] d);
        logic [7:0] r;
        r = rnd();
        @(posedge clk_sys);
        #1;
        sel_n = 1'b0;
        addr = {r[0], a};
        wr_data = di;
        wr_stb = w;
        rd_stb = !w;
        @(posedge clk_sys);
        #1;
        sel_n = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        d = rd_data;
    endtask
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_st(input logic [7:0] e, input logic [7:0] m);
        logic [7:0] s;
        bus(1'b0, 1'b0, 8'h00, s);
        chk8(e & m, s & m);
    endtask
    task automatic wait_st(input int b, input logic v);
        logic [7:0] s;
        for (int n = 0; n < 20000; n++) begin
            bus(1'b0, 1'b0, 8'h00, s);
            if (s[b] === v) return;
        end
        num_errors++;
        stop_test();
    endtask
    task automatic rx_chk(input logic [7:0] e);
        logic [7:0] d;
        bus(1'b0, 1'b1, 8'h00, d);
        chk8(e, d);
    endtask
    initial begin
        logic [7:0] b, c, d;
        repeat (5) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk_st(8'h00, 8'hA1);
        chk8(8'h01, {6'h00, rts_n, tx_line});
        bus(1'b1, 1'b1, 8'hAA, d);
        for (int r = 0; r < 3; r++) begin
            u_peer.bit_cyc = (r == 0) ? 2083 : (r == 1) ? 640 : 520;
            bus(1'b1, 1'b0, {6'h00, 2'(r)}, d);
            for (int k = 0; k < 2 - (r == 0); k++) begin
                b = rnd();
                bus(1'b1, 1'b1, b, d);
                exp_q.push_back(b);
            end
            if (r != 0) chk_st(8'h00, 8'h02);
            wait_st(1, 1'b1);
            for (int n = 0; n < 40000 && u_peer.got.size() < exp_q.size(); n++) @(posedge clk_sys);
            if (u_peer.got.size() < exp_q.size()) begin
                num_errors++;
                stop_test();
            end
            while (exp_q.size() > 0 && u_peer.got.size() > 0) chk8(exp_q.pop_front(), u_peer.got.pop_front());
            chk8(8'h00, 8'(exp_q.size()));
        end
        $display("test transmit done");
        @(posedge clk_sys);
        #1;
        cts_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        chk_st(8'h08, 8'h0A);
        cts_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        chk_st(8'h02, 8'h0A);
        for (int t = 0; t < 4; t++) begin
            bus(1'b1, 1'b0, {1'b0, 2'(t), 5'h01}, d);
            chk8({5'h00, t == 2, t == 1, t != 3}, {5'h00, rts_n, irq, tx_line});
        end
        bus(1'b1, 1'b0, 8'h01, d);
        bus(1'b1, 1'b1, rnd(), d);
        repeat (2000) @(posedge clk_sys);
        bus(1'b1, 1'b0, 8'h03, d);
        @(posedge clk_sys);
        #1;
        chk8(8'h01, {7'h00, tx_line});
        bus(1'b1, 1'b1, 8'hAA, d);
        repeat (7000) @(posedge clk_sys);
        u_peer.got.delete();
        $display("test control done");
        u_peer.bit_cyc = 640;
        bus(1'b1, 1'b0, 8'h81, d);
        b = rnd();
        u_peer.send(b, 1'b1);
        wait_st(0, 1'b1);
        chk_st(8'h81, 8'hB1);
        rx_chk(b);
        chk_st(8'h00, 8'hA1);
        b = rnd();
        c = rnd();
        u_peer.send(b, 1'b1);
        u_peer.send(c, 1'b1);
        wait_st(5, 1'b1);
        rx_chk(c);
        chk_st(8'h00, 8'h21);
        u_peer.send(b, 1'b0);
        wait_st(0, 1'b1);
        chk_st(8'h10, 8'h10);
        rx_chk(b);
        u_peer.send(c, 1'b1);
        wait_st(0, 1'b1);
        chk_st(8'h00, 8'h10);
        rx_chk(c);
        chk8(8'h00, 8'(u_peer.got.size()));
        $display("test receive done");
        stop_test();
    end
    initial begin
        repeat (98000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule // tb_msu_uart
bind msu_uart msu_uart_checker u_chk (.clk_sys(clk_sys), .rst(rst), .serial_port_select_n(serial_port_select_n),
    .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .rx_line(rx_line),
    .cts_n(cts_n), .tx_line(tx_line), .rts_n(rts_n), .irq(irq));
